/* logic/card_write_cache_flush.sv */
// Purpose: Card write cache with host flush and power-off write-back
// Assumes: Host data and power-off pulses arrive on sys_clk
// Notes: APB registers for control, status and feature flags
//
// Functional notes
// [RULE1] Advertise cache support in byte4 and b330
// [RULE2] Cache is invisible; card picks cached data
// [RULE3] Host flushes at least once before power-off
// [RULE4] Finish any flush within one second
// [RULE5] Hold DAT0 busy while flush runs
// [RULE6] Power-off notice writes whole cache back
// [RULE7] Flush end clears request, releases busy
module card_write_cache_flush #(
    parameter int unsigned FLUSH_LIMIT_CYCLES = cache_flush_pkg::FLUSH_LIMIT_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cache_flush_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host write data from the card bus
    input wire logic host_wr_valid,
    input wire logic [31:0] host_wr_addr,
    input wire logic [31:0] host_wr_data,
    output logic host_wr_ready,
    // Power-off notification from the command decoder
    input wire logic pwr_off_notify,
    // Non-volatile memory write port
    output logic nv_wr_valid,
    output logic [31:0] nv_wr_addr,
    output logic [31:0] nv_wr_data,
    input wire logic nv_wr_ready,
    // DAT0 busy drive, open-drain
    output logic dat0_out,
    output logic dat0_oe,
    // Feature advertisement
    output logic [7:0] perf_feature_support_field,
    output logic status_cache_support
);
    // Reset release synchroniser
    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_n;

    // Bus side
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic setup;
    logic wr_acc;
    logic ctrl_wr;
    logic stat_wr;
    logic flush_wr;
    logic pwroff_wr;

    // Control and status state
    logic cache_en_q;
    logic flush_pend_q;
    logic pwroff_pend_q;
    logic pwroff_done_q;
    logic tmo_q;
    logic busy_q;
    logic pending;
    logic done;
    logic expired;

    // Data path state
    cache_flush_pkg::wb_state_t state_q;
    logic host_rdy_q;
    logic nv_valid_q;
    logic [31:0] nv_addr_q;
    logic [31:0] nv_data_q;
    logic push;
    logic pop;
    logic wb_go;
    logic [31:0] head_addr;
    logic [31:0] head_data;
    logic [cache_flush_pkg::CNT_W-1:0] cnt;
    logic [cache_flush_pkg::CNT_W-1:0] cnt_nx;
    logic rdy_d;
    logic [7:0] perf_q;
    logic b330_q;

    // Release reset two edges after reset_n rises
    // Assertion stays asynchronous so the card goes quiet at once
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    // APB phase decode; writes land only at the completing access edge
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pready_q && pwrite;
    assign ctrl_wr = wr_acc && (paddr == cache_flush_pkg::CTRL_OFS);
    assign stat_wr = wr_acc && (paddr == cache_flush_pkg::STAT_OFS);
    assign flush_wr = ctrl_wr && pwdata[cache_flush_pkg::CTRL_FLUSH_BIT];
    assign pwroff_wr = ctrl_wr && pwdata[cache_flush_pkg::CTRL_PWROFF_BIT];

    // Zero-wait answer: pready is raised for the access cycle only
    // Unmapped offsets answer with an error and all-zero data
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= cache_flush_pkg::ZERO_WORD;
        end else begin
            pready_q <= setup;
            if (setup) begin
                prdata_q <= cache_flush_pkg::ZERO_WORD;
                pslverr_q <= 1'b0;
                case (paddr)
                    cache_flush_pkg::CTRL_OFS: begin
                        prdata_q[cache_flush_pkg::CTRL_FLUSH_BIT] <= flush_pend_q;
                        prdata_q[cache_flush_pkg::CTRL_EN_BIT] <= cache_en_q;
                        prdata_q[cache_flush_pkg::CTRL_PWROFF_BIT] <= pwroff_pend_q;
                    end
                    cache_flush_pkg::STAT_OFS: begin
                        prdata_q[cache_flush_pkg::STAT_BUSY_BIT] <= busy_q;
                        prdata_q[cache_flush_pkg::STAT_TMO_BIT] <= tmo_q;
                        prdata_q[cache_flush_pkg::STAT_PWROFF_DONE_BIT] <= pwroff_done_q;
                        prdata_q[cache_flush_pkg::STAT_CNT_LSB +: cache_flush_pkg::CNT_W]
                            <= cnt;
                    end
                    cache_flush_pkg::FEAT_OFS: begin
                        prdata_q[cache_flush_pkg::FEAT_BYTE4_BIT]
                            <= perf_q[cache_flush_pkg::PERF_CACHE_BIT]; // [RULE1]
                        prdata_q[cache_flush_pkg::FEAT_B330_BIT] <= b330_q; // [RULE1]
                        prdata_q[cache_flush_pkg::FEAT_PWROFF_BIT]
                            <= cache_flush_pkg::CACHE_SUPPORTED; // [RULE6]
                    end
                    default: pslverr_q <= 1'b1;
                endcase
            end
        end
    end

    // Cache enable is plain software state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) cache_en_q <= 1'b0;
        else if (ctrl_wr) cache_en_q <= pwdata[cache_flush_pkg::CTRL_EN_BIT];
    end

    // A flush ends once the cache is empty and no write-back is in flight
    // A push in the same cycle would refill the cache, so it holds done off
    assign pending = flush_pend_q || pwroff_pend_q;
    assign done = pending && (state_q == cache_flush_pkg::ST_IDLE)
                  && (cnt == cache_flush_pkg::CNT_ZERO) && !push;

    // Host flush request; a new request in the finishing cycle wins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) flush_pend_q <= 1'b0;
        else if (flush_wr) flush_pend_q <= 1'b1; // [RULE3]
        else if (done) flush_pend_q <= 1'b0; // [RULE7]
    end

    // Power-off notice from the bus or the register both start write-back
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwroff_pend_q <= 1'b0;
            pwroff_done_q <= 1'b0;
        end else begin
            if (pwr_off_notify || pwroff_wr) pwroff_pend_q <= 1'b1; // [RULE6]
            else if (done) pwroff_pend_q <= 1'b0; // [RULE7]
            if (pwroff_pend_q && done) pwroff_done_q <= 1'b1; // [RULE6]
        end
    end

    // Deadline watch; the small cache depth keeps write-back well under it
    // Expiry only flags the overrun; the write-back itself is never cut short
    flush_deadline_timer #(
        .LIMIT(FLUSH_LIMIT_CYCLES)
    ) u_timer (
        .clk(sys_clk),
        .rst_n(rst_n),
        .run(pending), // [RULE4]
        .expired(expired)
    );

    // Overrun flag is write-one-to-clear; a new overrun wins over the clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) tmo_q <= 1'b0;
        else if (expired) tmo_q <= 1'b1; // [RULE4]
        else if (stat_wr && pwdata[cache_flush_pkg::STAT_TMO_BIT]) tmo_q <= 1'b0;
    end

    // DAT0 is pulled low for as long as a flush request is open
    // Busy rises one cycle after the request is taken and falls one cycle
    // after the drain ends; a flush of an empty cache never shows busy
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            dat0_out <= 1'b0;
            dat0_oe <= 1'b0;
        end else begin
            busy_q <= pending && !done; // [RULE5] [RULE7]
            dat0_out <= 1'b0;
            dat0_oe <= pending && !done; // [RULE5]
        end
    end

    // Host writes go only into the cache; there is no host read-back path
    assign push = host_wr_valid && host_rdy_q; // [RULE2]
    assign cnt_nx = cnt + {3'b000, push} - {3'b000, pop};
    assign rdy_d = cache_en_q && !pending && !flush_wr && !pwroff_wr
                   && !pwr_off_notify && !pwroff_done_q
                   && (cnt_nx < cache_flush_pkg::CNT_FULL);

    // Ready is registered, so it looks one entry ahead of the fill level
    // Ready stays low after a completed power-off until the next reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) host_rdy_q <= 1'b0;
        else host_rdy_q <= rdy_d;
    end

    // The store has no host read port, which keeps the cache transparent
    write_cache_store u_store (
        .clk(sys_clk),
        .rst_n(rst_n),
        .push(push),
        .push_addr(host_wr_addr),
        .push_data(host_wr_data),
        .pop(pop),
        .head_addr(head_addr),
        .head_data(head_data),
        .count(cnt)
    );

    // Card decides when to drain: on flush, power-off, disable or a full cache
    assign wb_go = (state_q == cache_flush_pkg::ST_IDLE)
                   && (cnt != cache_flush_pkg::CNT_ZERO)
                   && (pending || !cache_en_q || cnt == cache_flush_pkg::CNT_FULL); // [RULE2]
    assign pop = wb_go;

    // Write-back: one entry at a time, held until the memory takes it
    // Only one word is in flight, so memory sees the entries oldest first
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= cache_flush_pkg::ST_IDLE;
            nv_valid_q <= 1'b0;
            nv_addr_q <= cache_flush_pkg::ZERO_WORD;
            nv_data_q <= cache_flush_pkg::ZERO_WORD;
        end else begin
            case (state_q)
                cache_flush_pkg::ST_IDLE: begin
                    if (wb_go) begin
                        nv_valid_q <= 1'b1; // [RULE6]
                        nv_addr_q <= head_addr;
                        nv_data_q <= head_data;
                        state_q <= cache_flush_pkg::ST_WB;
                    end
                end
                cache_flush_pkg::ST_WB: begin
                    if (nv_wr_ready) begin
                        nv_valid_q <= 1'b0;
                        state_q <= cache_flush_pkg::ST_IDLE;
                    end
                end
                default: begin
                    nv_valid_q <= 1'b0;
                    state_q <= cache_flush_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Support flags are fixed, but still driven from flops
    // They settle on the first edge after reset release, the third after reset_n rises, and never change
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            perf_q <= 8'h00;
            b330_q <= 1'b0;
        end else begin
            perf_q <= 8'h00;
            perf_q[cache_flush_pkg::PERF_CACHE_BIT] <= cache_flush_pkg::CACHE_SUPPORTED; // [RULE1]
            b330_q <= cache_flush_pkg::CACHE_SUPPORTED; // [RULE1]
        end
    end

    // Output hookup
    // Every output below is a flop of one of the processes above
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign host_wr_ready = host_rdy_q;
    assign nv_wr_valid = nv_valid_q;
    assign nv_wr_addr = nv_addr_q;
    assign nv_wr_data = nv_data_q;
    assign perf_feature_support_field = perf_q;
    assign status_cache_support = b330_q;
endmodule // card_write_cache_flush

/* logic/cache_flush_pkg.sv */
// Purpose: Shared constants for the card write cache and flush block
// Assumes: 100 MHz sys_clk, APB with 32-bit data
// Notes: Offsets are byte addresses of aligned words
package cache_flush_pkg;
    // Clock and flush deadline
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned FLUSH_LIMIT_S = 1;
    localparam int unsigned FLUSH_LIMIT_CYCLES = FLUSH_LIMIT_S * CLK_HZ;
    localparam int unsigned TMR_W = $clog2(FLUSH_LIMIT_CYCLES + 1);

    // Cache geometry, small enough to drain well inside the deadline
    localparam int unsigned ENTRIES = 8;
    localparam int unsigned PTR_W = 3;
    localparam int unsigned CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

    // APB register map
    localparam int unsigned APB_AW = 12;
    localparam logic [APB_AW-1:0] CTRL_OFS = 12'h000;
    localparam logic [APB_AW-1:0] STAT_OFS = 12'h004;
    localparam logic [APB_AW-1:0] FEAT_OFS = 12'h008;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // Control fields
    localparam int unsigned CTRL_FLUSH_BIT = 0;
    localparam int unsigned CTRL_EN_BIT = 1;
    localparam int unsigned CTRL_PWROFF_BIT = 2;
    // Status fields
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_TMO_BIT = 1;
    localparam int unsigned STAT_PWROFF_DONE_BIT = 2;
    localparam int unsigned STAT_CNT_LSB = 8;
    // Feature fields
    localparam int unsigned FEAT_BYTE4_BIT = 0;
    localparam int unsigned FEAT_B330_BIT = 1;
    localparam int unsigned FEAT_PWROFF_BIT = 2;

    // Support advertisement
    localparam logic CACHE_SUPPORTED = 1'b1;
    localparam int unsigned PERF_CACHE_BIT = 0;

    // Write-back state machine
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WB = 2'b01
    } wb_state_t;
endpackage

/* logic/write_cache_store.sv */
// Purpose: Entry array holding cached host writes, drained oldest first
// Assumes: Caller never pushes when full nor pops when empty
// Notes: No read port toward the host; only the write-back path sees it
module write_cache_store (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic push,
    input wire logic [31:0] push_addr,
    input wire logic [31:0] push_data,
    // Drain side
    input wire logic pop,
    output logic [31:0] head_addr,
    output logic [31:0] head_data,
    output logic [cache_flush_pkg::CNT_W-1:0] count
);
    logic [31:0] addr_mem [cache_flush_pkg::ENTRIES];
    logic [31:0] data_mem [cache_flush_pkg::ENTRIES];
    logic [cache_flush_pkg::PTR_W-1:0] wr_ptr_q;
    logic [cache_flush_pkg::PTR_W-1:0] rd_ptr_q;
    logic [cache_flush_pkg::CNT_W-1:0] cnt_q;

    // Storage has no reset; only pointers define what is valid
    always_ff @(posedge clk) begin
        if (push) begin
            addr_mem[wr_ptr_q] <= push_addr;
            data_mem[wr_ptr_q] <= push_data;
        end
    end

    // Pointers wrap naturally at the power-of-two depth
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= cache_flush_pkg::CNT_ZERO;
        end else begin
            if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
            if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
            if (push && !pop) cnt_q <= cnt_q + cache_flush_pkg::CNT_ONE;
            else if (pop && !push) cnt_q <= cnt_q - cache_flush_pkg::CNT_ONE;
        end
    end

    assign head_addr = addr_mem[rd_ptr_q];
    assign head_data = data_mem[rd_ptr_q];
    assign count = cnt_q;
endmodule // write_cache_store

/* logic/flush_deadline_timer.sv */
// Purpose: Measures how long a flush has been running
// Assumes: run stays high for the whole flush
// Notes: Pulses expired once when the limit is reached
module flush_deadline_timer #(
    parameter int unsigned LIMIT = cache_flush_pkg::FLUSH_LIMIT_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control and result
    input wire logic run,
    output logic expired
);
    localparam int unsigned W = cache_flush_pkg::TMR_W;
    localparam logic [W-1:0] LAST = W'(LIMIT - 1);
    logic [W-1:0] cnt_q;
    logic hit_q;

    // Counter saturates so expiry is reported only once per flush
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            hit_q <= 1'b0;
        end else if (!run) begin
            cnt_q <= '0;
            hit_q <= 1'b0;
        end else if (!hit_q) begin
            cnt_q <= cnt_q + 1'b1;
            hit_q <= (cnt_q == LAST);
        end
    end

    assign expired = run && !hit_q && (cnt_q == LAST);
endmodule // flush_deadline_timer

/* bench/card_cache_sva.sv */
// Purpose: Port-level checks of flush, busy drive and feature flags
// Assumes: Bound to card_write_cache_flush, one clock domain
// Notes: Cached entry count is mirrored here from the two handshakes
module card_cache_checker #(
    parameter int unsigned FLUSH_LIMIT_CYCLES = 100
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cache_flush_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Cache traffic
    input wire logic host_wr_valid,
    input wire logic host_wr_ready,
    input wire logic pwr_off_notify,
    input wire logic nv_wr_valid,
    input wire logic [31:0] nv_wr_addr,
    input wire logic [31:0] nv_wr_data,
    input wire logic nv_wr_ready,
    // Pin and flags
    input wire logic dat0_out,
    input wire logic dat0_oe,
    input wire logic [7:0] perf_feature_support_field,
    input wire logic status_cache_support
);
    logic [3:0] cnt_q;
    logic [31:0] busy_q;
    logic flush_wr;

    // Flush bit written at an APB access edge
    assign flush_wr = psel && penable && pready && pwrite && pwdata[0]
        && paddr == cache_flush_pkg::CTRL_OFS;

    // Entry mirror; push and pop may coincide, so both are summed
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'(host_wr_valid && host_wr_ready) - 4'(nv_wr_valid && nv_wr_ready);
        end
    end

    // Length of the current busy stretch
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= 32'h0000_0000;
        end else begin
            busy_q <= dat0_oe ? busy_q + 32'h0000_0001 : 32'h0000_0000;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    AST_FEAT_FLAGS: assert property (reset_n [*4] |->
        perf_feature_support_field == 8'h01 && status_cache_support) else $error("Feature flags");
    AST_APB_ANSWER: assert property (psel && !penable |=> pready)
        else $error("APB answer late");
    AST_NO_FILL_BUSY: assert property (dat0_oe |-> !host_wr_ready)
        else $error("Cache fill while busy");
    AST_FLUSH_BUSY: assert property (flush_wr && cnt_q > 4'h1 |-> ##2 dat0_oe)
        else $error("Flush without busy");
    AST_DAT0_LOW: assert property (dat0_oe |-> !dat0_out)
        else $error("Busy level not low");
    AST_DEADLINE: assert property (dat0_oe |-> busy_q < FLUSH_LIMIT_CYCLES)
        else $error("Flush too long");
    AST_RELEASE: assert property (dat0_oe && cnt_q == 4'h0 && !nv_wr_valid |=> !dat0_oe)
        else $error("Busy kept after drain");
    AST_PWROFF_BUSY: assert property (pwr_off_notify && cnt_q > 4'h1 |-> ##2 dat0_oe)
        else $error("Power-off without write-back");
    AST_NV_HOLD: assert property (nv_wr_valid && !nv_wr_ready |=> nv_wr_valid
        && $stable(nv_wr_addr) && $stable(nv_wr_data)) else $error("Write-back word dropped");
endmodule // card_cache_checker

bind card_write_cache_flush card_cache_checker #(.FLUSH_LIMIT_CYCLES(FLUSH_LIMIT_CYCLES)) u_chk (
    .sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .host_wr_valid,
    .host_wr_ready, .pwr_off_notify, .nv_wr_valid, .nv_wr_addr, .nv_wr_data, .nv_wr_ready,
    .dat0_out, .dat0_oe, .perf_feature_support_field, .status_cache_support);

/* bench/nv_memory_model.sv */
// Purpose: Non-volatile memory behind the write-back port
// Assumes: One word in flight at a time
// Notes: stall sets how many cycles each word waits for ready
module nv_memory_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pacing
    input wire logic [1:0] stall,
    // Write port
    input wire logic nv_wr_valid,
    input wire logic [31:0] nv_wr_addr,
    input wire logic [31:0] nv_wr_data,
    output logic nv_wr_ready
);
    logic [1:0] wait_q;
    logic [31:0] got_addr [0:31];
    logic [31:0] got_data [0:31];
    int n_got;

    // Ready is a one-cycle pulse so a held word is never taken twice
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nv_wr_ready <= 1'b0;
            wait_q <= 2'h0;
            n_got <= 0;
        end else if (nv_wr_ready) begin
            nv_wr_ready <= 1'b0;
            wait_q <= 2'h0;
            if (nv_wr_valid) begin
                got_addr[n_got] <= nv_wr_addr;
                got_data[n_got] <= nv_wr_data;
                n_got <= n_got + 1;
            end
        end else if (nv_wr_valid) begin
            if (wait_q >= stall) begin
                nv_wr_ready <= 1'b1;
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
endmodule // nv_memory_model

/* bench/tb_top.sv */
// Purpose: Register, flush and power-off tests of the card write cache
// Assumes: Short flush limit so the deadline stays visible
// Notes: Bus inputs change by non-blocking assignment after rising edges
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic [cache_flush_pkg::APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rd, host_wr_addr, host_wr_data, nv_wr_addr, nv_wr_data;
    logic host_wr_valid, host_wr_ready, pwr_off_notify, nv_wr_valid, nv_wr_ready;
    logic dat0_out, dat0_oe, status_cache_support;
    logic [7:0] perf_feature_support_field;
    logic [1:0] stall;
    logic [31:0] exp_a [0:31];
    logic [31:0] exp_d [0:31];
    int num_errors, compares, n_exp, busy_cyc;

`define CHK(what, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %h got %h", what, e, g); end end

    card_write_cache_flush #(.FLUSH_LIMIT_CYCLES(200)) uut (.sys_clk, .reset_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .host_wr_valid, .host_wr_addr,
        .host_wr_data, .host_wr_ready, .pwr_off_notify, .nv_wr_valid, .nv_wr_addr, .nv_wr_data,
        .nv_wr_ready, .dat0_out, .dat0_oe, .perf_feature_support_field, .status_cache_support);
    nv_memory_model nv (.clk(sys_clk), .rst_n(reset_n), .stall, .nv_wr_valid, .nv_wr_addr,
        .nv_wr_data, .nv_wr_ready);

    // Clock and busy-cycle monitor
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (dat0_oe === 1'b1) busy_cyc++;

    task automatic print_verdict();
        $display("Counts: %0d compares, %0d errors", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic timed_out();
        num_errors++;
        $display("CHECK FAILED wait exp done got timeout");
        print_verdict();
    endtask

    // APB transfer; pready is sampled at rising edges, data taken at the completing one
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (n == 16) timed_out();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Offer one word; the cache may hold it off while it drains
    task automatic host_wr(input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        host_wr_valid <= 1'b1;
        host_wr_addr <= a;
        host_wr_data <= d;
        for (n = 0; n < 64; n++) begin
            @(posedge sys_clk);
            if (host_wr_ready === 1'b1) break;
        end
        if (n == 64) timed_out();
        exp_a[n_exp] = a;
        exp_d[n_exp] = d;
        n_exp++;
        host_wr_valid <= 1'b0;
    endtask

    // Wait for memory to hold every word and busy to end, then compare in order
    task automatic drain_check();
        int n;
        for (n = 0; n < 500; n++) begin
            @(negedge sys_clk);
            if (nv.n_got == n_exp && dat0_oe === 1'b0 && nv_wr_valid === 1'b0) break;
        end
        if (n == 500) timed_out();
        for (int i = 0; i < n_exp; i++) begin
            `CHK("nv addr", exp_a[i], nv.got_addr[i])
            `CHK("nv data", exp_d[i], nv.got_data[i])
        end
    endtask

    // Main sequence
    initial begin
        {psel, penable, pwrite, host_wr_valid, pwr_off_notify, reset_n} = 6'h00;
        {paddr, pwdata, host_wr_addr, host_wr_data} = '0;
        {stall, num_errors, compares, n_exp, busy_cyc} = '0;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        apb(1'b0, cache_flush_pkg::FEAT_OFS, 32'h0000_0000);
        `CHK("feat", 32'h0000_0007, rd)
        `CHK("perf field", 8'h01, perf_feature_support_field)
        `CHK("status bit", 1'b1, status_cache_support)
        apb(1'b1, cache_flush_pkg::FEAT_OFS, 32'h0000_0000);
        apb(1'b0, cache_flush_pkg::FEAT_OFS, 32'h0000_0000);
        `CHK("feat ro", 32'h0000_0007, rd)
        apb(1'b0, cache_flush_pkg::CTRL_OFS, 32'h0000_0000);
        `CHK("ctrl reset", 32'h0000_0000, rd)
        apb(1'b0, 12'h00C, 32'h0000_0000);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0000_0000, rd)
        `CHK("ready disabled", 1'b0, host_wr_ready)
        $display("Test registers done");
        apb(1'b1, cache_flush_pkg::CTRL_OFS, 32'h0000_0002);
        // Prompt memory with 3 words, then slow memory with a full cache
        for (int s = 0; s < 2; s++) begin
            stall <= s ? 2'h3 : 2'h0;
            for (int i = 0; i < (s ? 8 : 3); i++) begin
                host_wr(32'h0000_1000 + 32'(n_exp * 4), 32'hA5A5_0000 + 32'(n_exp));
            end
            if (s == 0) apb(1'b0, cache_flush_pkg::STAT_OFS, 32'h0000_0000);
            if (s == 0) `CHK("count", 4'h3, rd[11:8])
            busy_cyc = 0;
            apb(1'b1, cache_flush_pkg::CTRL_OFS, 32'h0000_0003);
            apb(1'b1, cache_flush_pkg::CTRL_OFS, 32'h0000_0003);
            drain_check();
            `CHK("busy seen", 1'b1, busy_cyc inside {[1:200]})
            apb(1'b0, cache_flush_pkg::CTRL_OFS, 32'h0000_0000);
            `CHK("ctrl after", 32'h0000_0002, rd)
            apb(1'b0, cache_flush_pkg::STAT_OFS, 32'h0000_0000);
            `CHK("stat after", 32'h0000_0000, rd)
            $display("Test flush %0d done", s);
        end
        busy_cyc = 0;
        apb(1'b1, cache_flush_pkg::CTRL_OFS, 32'h0000_0003);
        repeat (4) @(posedge sys_clk);
        `CHK("empty flush busy", 0, busy_cyc)
        $display("Test empty flush done");
        host_wr(32'h0000_2000, 32'h5A5A_0001);
        host_wr(32'h0000_2004, 32'h5A5A_0002);
        @(posedge sys_clk);
        pwr_off_notify <= 1'b1;
        @(posedge sys_clk);
        pwr_off_notify <= 1'b0;
        drain_check();
        apb(1'b0, cache_flush_pkg::STAT_OFS, 32'h0000_0000);
        `CHK("pwroff done", 1'b1, rd[2])
        `CHK("ready after pwroff", 1'b0, host_wr_ready)
        $display("Test power-off done");
        // Second reset, then the register form of the power-off notice
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        n_exp = 0;
        repeat (3) @(posedge sys_clk);
        apb(1'b1, cache_flush_pkg::CTRL_OFS, 32'h0000_0002);
        host_wr(32'h0000_3000, 32'h3C3C_0001);
        apb(1'b1, cache_flush_pkg::CTRL_OFS, 32'h0000_0006);
        drain_check();
        apb(1'b0, cache_flush_pkg::STAT_OFS, 32'h0000_0000);
        `CHK("reg pwroff stat", 32'h0000_0004, rd)
        $display("Test reset and register power-off done");
        print_verdict();
    end
endmodule // tb_top
